// ---- shared/mipc_regs.vh ----
// Register layout, reset values and timing constants of the interrupt and power controller.
// Included by the controller; definitions only.
`ifndef MIPC_REGS_VH
`define MIPC_REGS_VH

// Register selects on the core's special-register port
`define MIPC_SEL_SFC         2'h0
`define MIPC_SEL_MASK        2'h1
`define MIPC_SEL_STATUS      2'h2
`define MIPC_SEL_CORECTL     2'h3

// Special function control fields
`define MIPC_SFC_PU5         0
`define MIPC_SFC_PU6         1
`define MIPC_SFC_RESUME      3
`define MIPC_SFC_RUN         4
`define MIPC_SFC_WDT_EN      5
`define MIPC_SFC_WAKE_DIS    6
`define MIPC_SFC_CLK_SEL     7
`define MIPC_SFC_RESET       8'hd7
`define MIPC_SFC_WMASK       8'hfb

// Interrupt source positions
`define MIPC_IRQ_TIMER       0
`define MIPC_IRQ_EP0         1
`define MIPC_IRQ_SUSPEND     2
`define MIPC_IRQ_BUSRST      3
`define MIPC_IRQ_PORT        4
`define MIPC_IRQ_SERIAL      5
`define MIPC_IRQ_RESUME      7
`define MIPC_MASK_RESET      8'h00
`define MIPC_MASK_VALID      8'hbf

// Core control: interrupt disable bit
`define MIPC_CORECTL_IDIS    6

// Vector address
`define MIPC_VECTOR          11'h001

// Slow-clock rates in Hz, selected by rate code
`define MIPC_CLK_HZ          40000000
`define MIPC_SLOW_HZ0        500
`define MIPC_SLOW_HZ1        4000
`define MIPC_SLOW_HZ2        32000
`define MIPC_SLOW_HZ3        256000

// Divider terminal counts (clock cycles per slow tick, minus one)
`define MIPC_SLOW_DIV0       17'h1387f
`define MIPC_SLOW_DIV1       17'h0270f
`define MIPC_SLOW_DIV2       17'h004e1
`define MIPC_SLOW_DIV3       17'h0009b

`endif

// ---- logic/mipc_ctrl.v ----
// Interrupt, wake-up and power-mode controller of a small USB-device microcontroller.
// Assumes single-cycle event pulses from timer, port detector, USB engine and core.
//
// Summary of operation
// - Clearing the run bit stops the system clock and enters sleep.
// - Run bit is one at power-on and set on wake signal falling edge.
// - Watchdog enable bit zero stops the watchdog, one lets it run.
// - Port-change wake is enabled when its bit is zero; USB engine sets it.
// - Clock-select zero runs core slowly and halts the USB engine.
// - Clock-select zero enables internal slow oscillator and stops external one.
// - Mask bits enable sources per bit; mask resets to zero.
// - Vectoring only while global enable set; enable/return set it, disable clears.
// - Host resume interrupt fires only in slow-clock mode; in sleep it wakes.
// - Accepted interrupts jump to the single vector address.
// - Timer overflow sets status bit 0.
// - Port 7 change sets status bit 4.
// - Endpoint 0 setup acceptance sets status bit 1.
// - USB suspend detection sets status bit 2.
// - USB bus reset sets status bit 3 and interrupts the core.
// - Leaving suspend without own resume sets status bit 7, except in sleep.
// - Status flags record regardless of the mask.
// - Power-on reset clears counter, timer, watchdog and loads register defaults.
// - Watchdog overflow restarts the core, leaving the USB engine untouched.
// - In sleep the oscillator is off; wake on resume, watchdog or port change.
// - Disable bit reads one after disable, zero after enable or return.
// - Resume request bit clears when USB suspend goes low.
// - Slow-clock rate bits select 500 Hz, 4 kHz, 32 kHz or 256 kHz.
`timescale 1ns/1ps
`include "mipc_regs.vh"

module mipc_ctrl (
	// Clock and power-on reset
	input  wire       clk,
	input  wire       sys_rst,
	// Core special-register port
	input  wire [1:0] reg_sel,
	input  wire       reg_wr,
	input  wire [7:0] reg_wdata,
	output reg  [7:0] reg_rdata,
	input  wire [7:0] status_clr,
	// Core instruction events
	input  wire       instr_eni,
	input  wire       instr_return_from_irq_instr,
	input  wire       instr_global_irq_disable_instr,
	input  wire       irq_ack,
	// Event sources
	input  wire       timer_ovf,
	input  wire       port7_change,
	input  wire       serial_done,
	input  wire       ep0_setup,
	input  wire       usb_suspend,
	input  wire       usb_bus_reset,
	input  wire       usb_wake_dis_set,
	input  wire       watchdog_ovf,
	input  wire       wake_signal,
	input  wire [1:0] slow_rate_sel,
	// Core control outputs
	output wire       irq_req,
	output wire [10:0] irq_vector,
	output reg        core_restart,
	output wire       sys_clk_en,
	output wire       slow_tick,
	output wire       ext_osc_en,
	output wire       int_osc_en,
	output wire       usb_engine_en,
	output wire       watchdog_run,
	output wire       port_wake_en,
	output wire       resume_signal,
	output wire       pullup_dis_p5,
	output wire       pullup_dis_p6
);

	// =========================================================
	// Registers
	reg  [7:0]  sfc;
	reg  [7:0]  irq_mask;
	reg  [7:0]  irq_status;
	reg         irq_dis;
	reg         wake_d;
	reg         suspend_d;
	reg  [16:0] slow_cnt;
	reg  [16:0] slow_div;
	reg  [7:0]  next_status;
	wire [7:0]  events;
	wire        run;
	wire        wake_fall;
	wire        suspend_fall;
	wire        resume_wake;
	wire        wake_any;

	assign run          = sfc[`MIPC_SFC_RUN];
	assign wake_fall    = wake_d & ~wake_signal;
	assign suspend_fall = suspend_d & ~usb_suspend;

	// =========================================================
	// Event capture
	assign events[`MIPC_IRQ_TIMER]   = timer_ovf;
	assign events[`MIPC_IRQ_EP0]     = ep0_setup;
	assign events[`MIPC_IRQ_SUSPEND] = usb_suspend & ~suspend_d;
	assign events[`MIPC_IRQ_BUSRST]  = usb_bus_reset;
	assign events[`MIPC_IRQ_PORT]    = port7_change;
	assign events[`MIPC_IRQ_SERIAL]  = serial_done;
	assign events[6]                 = 1'b0;
	assign events[`MIPC_IRQ_RESUME]  = suspend_fall & ~sfc[`MIPC_SFC_RESUME];

	// Host resume in sleep wakes, port change wakes only if enabled
	assign resume_wake = events[`MIPC_IRQ_RESUME] & ~run;
	assign wake_any    = wake_fall | resume_wake | watchdog_ovf
	                   | (port7_change & ~sfc[`MIPC_SFC_WAKE_DIS]);

	// Status: set wins over firmware clear; written regardless of mask
	always @* begin
		next_status = (irq_status & ~status_clr) | events;
		if (!run)
			next_status[`MIPC_IRQ_RESUME] = irq_status[`MIPC_IRQ_RESUME]
			                              & ~status_clr[`MIPC_IRQ_RESUME];
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			irq_status <= 8'h00;
			wake_d     <= 1'b1;
			suspend_d  <= 1'b0;
		end else begin
			irq_status <= next_status & `MIPC_MASK_VALID;
			wake_d     <= wake_signal;
			suspend_d  <= usb_suspend;
		end
	end

	// =========================================================
	// Special function control, mask and global enable
	always @(posedge clk) begin
		if (sys_rst) begin
			sfc      <= `MIPC_SFC_RESET;
			irq_mask <= `MIPC_MASK_RESET;
			irq_dis  <= 1'b1;
		end else begin
			if (reg_wr && reg_sel == `MIPC_SEL_SFC)
				sfc <= (reg_wdata & `MIPC_SFC_WMASK) | (sfc & ~`MIPC_SFC_WMASK);
			if (reg_wr && reg_sel == `MIPC_SEL_MASK)
				irq_mask <= reg_wdata & `MIPC_MASK_VALID;
			if (usb_wake_dis_set)
				sfc[`MIPC_SFC_WAKE_DIS] <= 1'b1;
			if (suspend_fall)
				sfc[`MIPC_SFC_RESUME] <= 1'b0;
			if (wake_any)
				sfc[`MIPC_SFC_RUN] <= 1'b1;
			if (watchdog_ovf) begin
				irq_mask <= `MIPC_MASK_RESET;
				irq_dis  <= 1'b1;
			end else if (instr_global_irq_disable_instr || irq_ack)
				irq_dis <= 1'b1;
			else if (instr_eni || instr_return_from_irq_instr)
				irq_dis <= 1'b0;
		end
	end

	// Watchdog restart pulse, USB engine untouched
	always @(posedge clk) begin
		if (sys_rst)
			core_restart <= 1'b0;
		else
			core_restart <= watchdog_ovf;
	end

	// =========================================================
	// Interrupt request and vector
	// Host resume only requests in slow-clock mode
	assign irq_req    = run & ~irq_dis
	                  & |(irq_status & irq_mask & {~sfc[`MIPC_SFC_CLK_SEL], 7'h7f});
	assign irq_vector = `MIPC_VECTOR;

	// =========================================================
	// Slow clock enable divider
	always @* begin
		case (slow_rate_sel)
			2'b00:   slow_div = `MIPC_SLOW_DIV0;
			2'b01:   slow_div = `MIPC_SLOW_DIV1;
			2'b10:   slow_div = `MIPC_SLOW_DIV2;
			2'b11:   slow_div = `MIPC_SLOW_DIV3;
			default: slow_div = `MIPC_SLOW_DIV0;
		endcase
	end

	always @(posedge clk) begin
		if (sys_rst || sfc[`MIPC_SFC_CLK_SEL])
			slow_cnt <= 17'h00000;
		else if (slow_cnt >= slow_div)
			slow_cnt <= 17'h00000;
		else
			slow_cnt <= slow_cnt + 17'h00001;
	end

	assign slow_tick = run & ~sfc[`MIPC_SFC_CLK_SEL] & (slow_cnt >= slow_div);

	// =========================================================
	// Power and clock control outputs
	assign sys_clk_en    = run;
	assign ext_osc_en    = run & sfc[`MIPC_SFC_CLK_SEL];
	assign int_osc_en    = run & ~sfc[`MIPC_SFC_CLK_SEL];
	assign usb_engine_en = sfc[`MIPC_SFC_CLK_SEL];
	assign watchdog_run  = sfc[`MIPC_SFC_WDT_EN];
	assign port_wake_en  = ~sfc[`MIPC_SFC_WAKE_DIS];
	assign resume_signal = sfc[`MIPC_SFC_RESUME];
	assign pullup_dis_p5 = sfc[`MIPC_SFC_PU5];
	assign pullup_dis_p6 = sfc[`MIPC_SFC_PU6];

	// =========================================================
	// Read-back
	always @* begin
		case (reg_sel)
			`MIPC_SEL_SFC:    reg_rdata = sfc;
			`MIPC_SEL_MASK:   reg_rdata = irq_mask;
			`MIPC_SEL_STATUS: reg_rdata = irq_status;
			`MIPC_SEL_CORECTL: reg_rdata = {1'b0, irq_dis, 6'h00};
			default:          reg_rdata = 8'h00;
		endcase
	end

endmodule

// ---- sim/mipc_ctrl_checker.sv ----
// Port checker for the interrupt and power controller.
// Bound to every mipc_ctrl instance; sees its ports only.
`timescale 1ns/1ps
module mipc_ctrl_checker (
	input wire        clk, sys_rst, reg_wr, instr_global_irq_disable_instr, timer_ovf, port7_change,
	input wire        usb_suspend, watchdog_ovf, wake_signal, irq_req, core_restart,
	input wire        sys_clk_en, int_osc_en, usb_engine_en, watchdog_run, resume_signal,
	input wire [1:0]  reg_sel,
	input wire [7:0]  reg_wdata, reg_rdata,
	input wire [10:0] irq_vector
);
	// ====================
	// Assertions
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	chk_vector_fixed: assert property (irq_vector == 11'h001)
		else $error("vector moved");
	chk_run_clear: assert property (reg_wr && reg_sel == 2'h0 && !reg_wdata[4] |=> !sys_clk_en)
		else $error("clock kept in sleep");
	chk_wake_run: assert property ($fell(wake_signal) |-> ##[1:2] sys_clk_en)
		else $error("no wake");
	chk_wdt_follow: assert property (reg_wr && reg_sel == 2'h0 |=> watchdog_run == $past(reg_wdata[5]))
		else $error("watchdog enable wrong");
	chk_clk_select: assert property (reg_wr && reg_sel == 2'h0 && reg_wdata[4] |=>
		usb_engine_en == $past(reg_wdata[7]) && int_osc_en != $past(reg_wdata[7]))
		else $error("clock select wrong");
	chk_timer_flag: assert property (timer_ovf |=> reg_sel != 2'h2 || reg_rdata[0])
		else $error("timer flag lost");
	chk_port_flag: assert property (port7_change |=> reg_sel != 2'h2 || reg_rdata[4])
		else $error("port flag lost");
	chk_global_irq_disable_instr_block: assert property (instr_global_irq_disable_instr |=> !irq_req)
		else $error("request while disabled");
	chk_dog_restart: assert property (watchdog_ovf |=> core_restart ##1 !core_restart)
		else $error("restart pulse wrong");
	chk_resume_drop: assert property ($fell(usb_suspend) |-> ##[1:2] !resume_signal)
		else $error("resume kept");
endmodule

bind mipc_ctrl mipc_ctrl_checker u_chk (.*);

// ---- sim/mipc_usb_model.sv ----
// USB engine model: acts on a request after a chosen delay.
// Assumes one-cycle requests sampled on the rising clock.
`timescale 1ns/1ps
module mipc_usb_model (
	input wire       clk,
	input wire [2:0] req,
	input wire [3:0] dly,
	output reg       ep0_setup = 0, usb_bus_reset = 0, usb_suspend = 0, usb_wake_dis_set = 0
);
	reg [2:0] pend = 0;
	reg [3:0] cnt = 0;
	always @(posedge clk) begin
		{ep0_setup, usb_bus_reset, usb_wake_dis_set} <= 3'h0;
		if (req != 3'h0) begin
			pend <= req;
			cnt <= dly;
		end else if (pend != 3'h0 && cnt != 4'h0) cnt <= cnt - 4'h1;
		else if (pend != 3'h0) begin
			ep0_setup <= pend[0];
			usb_bus_reset <= pend[1];
			usb_wake_dis_set <= pend[1];
			if (pend[2]) usb_suspend <= ~usb_suspend;
			pend <= 3'h0;
		end
	end
endmodule

// ---- sim/mipc_ctrl_bench.sv ----
// Self-checking bench for mipc_ctrl with a USB engine model.
// Inputs change on the falling clock; reads are queued and compared.
`timescale 1ns/1ps
module mipc_ctrl_bench;
	reg        clk = 0, sys_rst = 1, reg_wr = 0, wake_signal = 1, rd_en = 0;
	reg  [1:0] reg_sel = 0, slow_rate_sel = 0;
	reg  [7:0] reg_wdata = 0, w;
	reg [23:0] ev = 0;
	reg  [2:0] req = 0;
	reg  [3:0] dly = 0;
	reg  [9:0] q_exp[$], q_msk[$], e, m;
	reg [47:0] tbl = 48'h02_08_04_00_04_80;
	wire [7:0] reg_rdata, status_clr;
	wire [10:0] irq_vector;
	wire       irq_req, sys_clk_en, ep0_setup, usb_bus_reset, usb_suspend, usb_wake_dis_set;
	wire       core_restart, slow_tick, ext_osc_en, int_osc_en, usb_engine_en, watchdog_run;
	wire       port_wake_en, resume_signal, pullup_dis_p5, pullup_dis_p6;
	wire       timer_ovf = ev[0], port7_change = ev[4], serial_done = ev[5], instr_eni = ev[8];
	wire       instr_return_from_irq_instr = ev[9], instr_global_irq_disable_instr = ev[10], irq_ack = ev[11], watchdog_ovf = ev[12];
	integer    miscompares = 0, num_checks = 0, cyc = 0, i;
	assign status_clr = ev[23:16];
	always #12.5 clk = ~clk;
	mipc_usb_model u_mipc_usb_model (.*);
	mipc_ctrl u_mipc_ctrl (.*);
	task tick(input integer n); repeat (n) @(negedge clk); endtask
	task wr(input [1:0] s, input [7:0] d); begin
		reg_sel = s; reg_wdata = d; reg_wr = 1; tick(1); reg_wr = 0; tick(1);
	end endtask
	task rd(input [1:0] s, input [9:0] x, input [9:0] k); begin
		reg_sel = s; q_exp.push_back(x); q_msk.push_back(k); rd_en = 1; tick(1); rd_en = 0; tick(1);
	end endtask
	task pulse(input [23:0] p); begin ev = p; tick(1); ev = 0; tick(1); end endtask
	task test_done; begin
		if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	end endtask
	// ====================
	// Result watcher and timeout
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin miscompares = miscompares + 1; test_done; end
		if (rd_en) begin
			e = q_exp.pop_front(); m = q_msk.pop_front(); num_checks = num_checks + 1;
			if ((({sys_clk_en, irq_req, reg_rdata} ^ e) & m) !== 10'h0) begin
				miscompares = miscompares + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, {sys_clk_en, irq_req, reg_rdata} & m, e);
			end
		end
	end
	// ====================
	// Scenarios
	initial begin
		w = $urandom(99898); slow_rate_sel = $urandom; tick(5); sys_rst = 0;
		rd(0, 10'h2d7, 10'h2ff); rd(1, 0, 10'h0ff); rd(2, 0, 10'h0ff); rd(3, 10'h040, 10'h040);
		w = $urandom; wr(1, w); rd(1, w & 8'hbf, 10'h0ff); wr(1, 0);
		for (i = 0; i < 3; i++) begin
			pulse(24'h1 << (i ? i + 3 : 0)); rd(2, 10'h1 << (i ? i + 3 : 0), 10'h0ff);
			pulse(24'hff0000); rd(2, 0, 10'h0ff);
		end
		wr(0, 8'h9f);
		for (i = 0; i < 6; i++) begin
			dly = $urandom; req = i == 0 ? 3'h1 : i == 1 ? 3'h2 : 3'h4; tick(1); req = 0; tick(18);
			rd(2, tbl[47 - 8 * i -: 8], 10'h0ff); pulse(24'hff0000);
		end
		rd(0, 10'h2d7, 10'h2ff);
		wr(1, 8'h80); pulse(24'h100); req = 3'h4; tick(1); req = 0; tick(18);
		req = 3'h4; tick(1); req = 0; tick(18);
		rd(2, 10'h284, 10'h3ff); wr(0, 8'h57); rd(2, 10'h384, 10'h3ff);
		pulse(24'hff0400); wr(0, 8'hd7); wr(1, 0);
		wr(1, 8'h01); pulse(24'h1); rd(2, 10'h201, 10'h3ff);
		pulse(24'h100); rd(2, 10'h301, 10'h3ff); rd(3, 0, 10'h040);
		pulse(24'h400); rd(2, 10'h201, 10'h3ff); pulse(24'h200); rd(2, 10'h301, 10'h3ff);
		pulse(24'h800); rd(3, 10'h040, 10'h040); pulse(24'h100);
		wr(1, 0); rd(2, 10'h201, 10'h3ff); pulse(24'hff0000);
		wr(0, 8'hc7); rd(0, 10'h0c7, 10'h2ff); wake_signal = 0; tick(3);
		wake_signal = 1; rd(0, 10'h2d7, 10'h2ff);
		wr(0, 8'h77); rd(0, 10'h277, 10'h2ff); wr(0, 8'hd7);
		wr(1, 8'hbf); pulse(24'h1000); rd(1, 0, 10'h0ff); rd(0, 10'h2d7, 10'h2ff);
		test_done;
	end
endmodule
